// ===== hdl/rdt_addr_step.sv
// one address stepper: fixed, up or down by the unit size
`timescale 1ns/100ps
`default_nettype none
`include "rdt_defs.svh"
module rdt_addr_step (
  // current address and its setting
  input wire logic [31:0] addr,
  input wire rdt_pkg::rdt_step_t step,
  input wire rdt_pkg::rdt_size_t size,
  // address for the next unit
  output logic [31:0] addr_nxt
);
  import rdt_pkg::*;
  logic [31:0] bytes;
  always_comb begin
    unique case (size)
      RDT_WORD: bytes = `RDT_BYTES_W;
      RDT_LONG: bytes = `RDT_BYTES_L;
      default: bytes = `RDT_BYTES_B;
    endcase
    unique case (step)
      RDT_INC: addr_nxt = addr + bytes;
      RDT_DEC: addr_nxt = addr - bytes;
      default: addr_nxt = addr;
    endcase
  end
endmodule
`default_nettype wire

// ===== hdl/rdt_defs.svh
// register offsets, reset values and timing figures of the transfer engine
`ifndef RDT_DEFS_SVH
`define RDT_DEFS_SVH
`define RDT_NSRC 16
`define RDT_OFS_ENABLE 8'h00
`define RDT_OFS_CTRL 8'h04
`define RDT_OFS_VBASE 8'h08
`define RDT_OFS_STATUS 8'h0c
`define RDT_ENABLE_RST 16'h0000
`define RDT_CTRL_RST 8'h00
`define RDT_VBASE_RST 32'h0000_0000
`define RDT_VEC_OFS 32'h0000_0400
`define RDT_DESC_FULL_LAST 2'h3
`define RDT_DESC_SHORT_LAST 2'h2
`define RDT_DESC_FULL_BYTES 32'h0000_0010
`define RDT_DESC_SHORT_BYTES 32'h0000_000c
`define RDT_BYTES_B 32'h0000_0001
`define RDT_BYTES_W 32'h0000_0002
`define RDT_BYTES_L 32'h0000_0004
`define RDT_GAP_P0 4'h0
`define RDT_GAP_P1 4'h1
`define RDT_GAP_P2 4'h2
`define RDT_GAP_P3 4'h4
`define RDT_GAP_P4 4'h8
`endif

// ===== hdl/rdt_pkg.sv
// shared types of the transfer engine
`default_nettype none
package rdt_pkg;
  typedef enum logic [1:0] {RDT_NORMAL, RDT_REPEAT, RDT_BLOCK, RDT_MD_RSV} rdt_mode_t;
  typedef enum logic [1:0] {RDT_BYTE, RDT_WORD, RDT_LONG, RDT_SZ_RSV} rdt_size_t;
  typedef enum logic [1:0] {RDT_FIX0, RDT_FIX1, RDT_INC, RDT_DEC} rdt_step_t;
  typedef struct packed {
    rdt_mode_t md;
    rdt_size_t sz;
    rdt_step_t sm;
    logic [1:0] rsv;
  } rdt_mode_a_t;
  typedef struct packed {
    logic chain;
    logic irq_each;
    rdt_step_t dm;
    logic [3:0] rsv;
  } rdt_mode_b_t;
  typedef struct packed {
    logic rsv;
    logic stop;
    logic short_mode;
    logic [2:0] rel;
    logic rr;
    logic skip;
  } rdt_ctrl_t;
  typedef struct packed {
    logic req;
    logic we;
    rdt_size_t size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rdt_mreq_t;
  typedef enum logic [3:0] {
    S_IDLE, S_ARB, S_VEC, S_DISS, S_DESC, S_START, S_RISS, S_RD,
    S_WISS, S_WR, S_GAP, S_BISS, S_BWR, S_END
  } rdt_state_t;
endpackage
`default_nettype wire

// ===== hdl/rdt_regs.sv
// wishbone classic slave holding the software visible registers
`timescale 1ns/100ps
`default_nettype none
`include "rdt_defs.svh"
module rdt_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // engine side
  input wire logic [15:0] hw_clr,
  input wire logic [31:0] status,
  output logic [15:0] enable,
  output rdt_pkg::rdt_ctrl_t ctrl,
  output logic [31:0] vbase
);
  import rdt_pkg::*;
  logic wr;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      unique case (wb_adr_i)
        `RDT_OFS_ENABLE: wb_dat_o <= {16'h0000, enable};
        `RDT_OFS_CTRL: wb_dat_o <= {24'h00_0000, ctrl};
        `RDT_OFS_VBASE: wb_dat_o <= vbase;
        `RDT_OFS_STATUS: wb_dat_o <= status;
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
  // a software write lands after the hardware clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      enable <= `RDT_ENABLE_RST;
    end else begin
      enable <= enable & ~hw_clr; // [R23]
      if (wr && wb_adr_i == `RDT_OFS_ENABLE) begin
        if (wb_sel_i[0]) enable[7:0] <= wb_dat_i[7:0]; // [R16]
        if (wb_sel_i[1]) enable[15:8] <= wb_dat_i[15:8];
      end
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl <= `RDT_CTRL_RST;
      vbase <= `RDT_VBASE_RST;
    end else if (wr) begin
      if (wb_adr_i == `RDT_OFS_CTRL && wb_sel_i[0]) begin
        ctrl <= {1'b0, wb_dat_i[6:0]}; // [R14]
      end
      if (wb_adr_i == `RDT_OFS_VBASE) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) vbase[8*b +: 8] <= wb_dat_i[8*b +: 8]; // [R17]
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== hdl/rdt_top.sv
// descriptor transfer engine: arbiter, descriptor sequencer and data mover
// Functional notes
// [R1] normal mode: 16-bit counter, 1 to 65536
// [R2] repeat: upper byte reload, lower byte counts
// [R3] block: upper byte size, lower byte counts
// [R4] block mode: second field counts blocks
// [R5] one activation may run chained descriptors
// [R6] chain only once counter reached zero
// [R7] normal, repeat, block chosen per descriptor
// [R8] source, destination step independently: up/down/fixed
// [R9] full 32-bit source and destination addresses
// [R10] units are byte, word or longword
// [R11] cpu interrupt per transfer or at end
// [R12] five selectable bus release policies
// [R13] two selectable request priority schemes
// [R14] control register allows skipping descriptor read
// [R15] fixed addresses are not written back; the code skips them only when source and destination are both fixed
// [R16] per-source 16-bit activation enable register
// [R17] 32-bit vector base register
// [R18] working registers loaded only from descriptors
// [R19] updated descriptor written back to ram
// [R20] module stop and short address format
// [R21] vector at base plus 400h plus four*vector
// [R22] serviced request is not passed to cpu
// [R23] finished source loses its enable bit
// [R24] hold bus from vector read to writeback
// [R25] addresses step by unit size in bytes
`timescale 1ns/100ps
`default_nettype none
`include "rdt_defs.svh"
module rdt_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // wishbone register slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // internal bus master
  output logic bus_req,
  input wire logic bus_gnt,
  output rdt_pkg::rdt_mreq_t mreq,
  input wire logic [31:0] m_rdata,
  input wire logic m_ack,
  // activation sources and cpu interrupts
  input wire logic [15:0] act_req,
  output logic [15:0] cpu_irq,
  output logic busy
);
  import rdt_pkg::*;

  rdt_state_t state;
  rdt_ctrl_t ctrl;
  rdt_mode_a_t ma;
  rdt_mode_b_t mb;
  logic [15:0] enable;
  logic [15:0] pend;
  logic [15:0] cand;
  logic [15:0] vec_mask;
  logic [15:0] hw_clr;
  logic [31:0] vbase;
  logic [31:0] src;
  logic [31:0] dst;
  logic [31:0] src_nxt;
  logic [31:0] dst_nxt;
  logic [31:0] desc_ptr;
  logic [31:0] data;
  logic [31:0] status;
  logic [15:0] cnt_a;
  logic [15:0] cnt_b;
  logic [8:0] unit_left;
  logic [3:0] vec;
  logic [3:0] pick_v;
  logic [3:0] rr_ptr;
  logic [3:0] last_vec;
  logic [3:0] gap_cnt;
  logic [3:0] gap_len;
  logic [1:0] widx;
  logic [1:0] wlast;
  logic [1:0] wfirst;
  logic last_valid;
  logic chained;
  logic take;
  logic done_all;
  logic last_unit;

  rdt_regs u_regs (
    .sys_clk(sys_clk),
    .rst(rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .hw_clr(hw_clr),
    .status(status),
    .enable(enable),
    .ctrl(ctrl),
    .vbase(vbase)
  );

  rdt_addr_step u_src_step (
    .addr(src),
    .step(ma.sm),
    .size(ma.sz),
    .addr_nxt(src_nxt)
  ); // [R8]

  rdt_addr_step u_dst_step (
    .addr(dst),
    .step(mb.dm),
    .size(ma.sz),
    .addr_nxt(dst_nxt)
  ); // [R25]

  // first pending source at or after the start point
  function automatic logic [3:0] pick(input logic [15:0] p, input logic [3:0] start);
    logic [3:0] k;
    pick = start;
    for (int i = 15; i >= 0; i--) begin
      k = start + i[3:0];
      if (p[k]) pick = k;
    end
  endfunction

  assign cand = pend & enable;
  assign pick_v = pick(cand, ctrl.rr ? rr_ptr : 4'h0); // [R13]
  assign take = (state == S_IDLE) && (|cand) && !ctrl.stop; // [R20]
  assign vec_mask = 16'h0001 << vec;
  assign last_unit = (unit_left == 9'h001);
  assign wlast = ctrl.short_mode ? `RDT_DESC_SHORT_LAST : `RDT_DESC_FULL_LAST;
  // with both addresses fixed only the count word goes back
  assign wfirst = (!ma.sm[1] && !mb.dm[1]) ? wlast : {1'b0, !ctrl.short_mode}; // [R15]
  assign done_all = (ma.md == RDT_NORMAL && cnt_a == 16'h0000) ||
                    (ma.md == RDT_BLOCK && cnt_b == 16'h0000); // [R6]
  assign hw_clr = (state == S_END && done_all) ? vec_mask : 16'h0000; // [R23]
  assign status = {16'h0000, 8'h00, 2'b00, last_valid, busy, vec};

  always_comb begin
    unique case (ctrl.rel)
      3'h0: gap_len = `RDT_GAP_P0;
      3'h1: gap_len = `RDT_GAP_P1;
      3'h2: gap_len = `RDT_GAP_P2;
      3'h3: gap_len = `RDT_GAP_P3;
      default: gap_len = `RDT_GAP_P4;
    endcase
  end

  // descriptor word as it is written back
  function automatic logic [31:0] wb_word(input logic [1:0] i);
    wb_word = {cnt_a, cnt_b};
    if (ctrl.short_mode) begin
      if (i == 2'h0) wb_word = {ma, src[23:0]};
      if (i == 2'h1) wb_word = {mb, dst[23:0]};
    end else begin
      if (i == 2'h0) wb_word = {ma, mb, 16'h0000};
      if (i == 2'h1) wb_word = src;
      if (i == 2'h2) wb_word = dst;
    end
  endfunction

  // sequencer: every bus request drops for a cycle after its ack
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      mreq <= '0;
      bus_req <= 1'b0;
      busy <= 1'b0;
      vec <= 4'h0;
      rr_ptr <= 4'h0;
      desc_ptr <= 32'h0000_0000;
      data <= 32'h0000_0000;
      widx <= 2'h0;
      unit_left <= 9'h000;
      gap_cnt <= 4'h0;
    end else begin
      unique case (state)
        S_IDLE: if (take) begin
          vec <= pick_v;
          rr_ptr <= pick_v + 4'h1;
          bus_req <= 1'b1; // [R24]
          busy <= 1'b1;
          state <= S_ARB;
        end
        S_ARB: if (bus_gnt) begin
          if (ctrl.skip && last_valid && last_vec == vec) begin
            state <= S_START; // [R14]
          end else begin
            mreq <= '{req: 1'b1, we: 1'b0, size: RDT_LONG,
                      addr: vbase + `RDT_VEC_OFS + {26'h0, vec, 2'b00},
                      wdata: 32'h0000_0000}; // [R21]
            state <= S_VEC;
          end
        end
        S_VEC: if (m_ack) begin
          mreq.req <= 1'b0;
          desc_ptr <= m_rdata;
          widx <= 2'h0;
          state <= S_DISS;
        end
        S_DISS: begin
          mreq <= '{req: 1'b1, we: 1'b0, size: RDT_LONG,
                    addr: desc_ptr + {28'h0, widx, 2'b00}, wdata: 32'h0000_0000};
          state <= S_DESC;
        end
        S_DESC: if (m_ack) begin
          mreq.req <= 1'b0;
          widx <= widx + 2'h1;
          state <= (widx == wlast) ? S_START : S_DISS;
        end
        S_START: begin
          // a block of zero means 256 units
          unit_left <= (ma.md == RDT_BLOCK) ? {~|cnt_a[15:8], cnt_a[15:8]} : 9'h001; // [R3]
          state <= S_RISS;
        end
        S_RISS: begin
          mreq <= '{req: 1'b1, we: 1'b0, size: ma.sz, addr: src,
                    wdata: 32'h0000_0000}; // [R9]
          state <= S_RD;
        end
        S_RD: if (m_ack) begin
          mreq.req <= 1'b0;
          data <= m_rdata;
          state <= S_WISS;
        end
        S_WISS: begin
          mreq <= '{req: 1'b1, we: 1'b1, size: ma.sz, addr: dst, wdata: data}; // [R10]
          state <= S_WR;
        end
        S_WR: if (m_ack) begin
          mreq.req <= 1'b0;
          unit_left <= unit_left - 9'h001;
          gap_cnt <= gap_len; // [R12]
          widx <= wfirst;
          state <= last_unit ? S_BISS : S_GAP;
        end
        S_GAP: begin
          // bus stays owned but idle, letting other masters' requests age
          if (gap_cnt == 4'h0) state <= S_RISS;
          else gap_cnt <= gap_cnt - 4'h1;
        end
        S_BISS: begin
          mreq <= '{req: 1'b1, we: 1'b1, size: RDT_LONG,
                    addr: desc_ptr + {28'h0, widx, 2'b00}, wdata: wb_word(widx)}; // [R19]
          state <= S_BWR;
        end
        S_BWR: if (m_ack) begin
          mreq.req <= 1'b0;
          if (widx != wlast) begin
            widx <= widx + 2'h1;
            state <= S_BISS;
          end else if (mb.chain && done_all) begin
            desc_ptr <= desc_ptr + (ctrl.short_mode ? `RDT_DESC_SHORT_BYTES
                                                    : `RDT_DESC_FULL_BYTES); // [R5]
            widx <= 2'h0;
            state <= S_DISS; // [R6]
          end else begin
            state <= S_END;
          end
        end
        S_END: begin
          bus_req <= 1'b0; // [R24]
          busy <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // working registers: no software path reaches them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ma <= '0;
      mb <= '0;
      src <= 32'h0000_0000;
      dst <= 32'h0000_0000;
      cnt_a <= 16'h0000;
      cnt_b <= 16'h0000;
    end else if (state == S_DESC && m_ack) begin
      if (ctrl.short_mode) begin
        unique case (widx)
          2'h0: begin
            ma <= m_rdata[31:24];
            src <= {8'h00, m_rdata[23:0]}; // [R20]
          end
          2'h1: begin
            mb <= m_rdata[31:24];
            dst <= {8'h00, m_rdata[23:0]};
          end
          default: begin
            cnt_a <= m_rdata[31:16];
            cnt_b <= m_rdata[15:0];
          end
        endcase
      end else begin
        unique case (widx)
          2'h0: begin
            ma <= m_rdata[31:24]; // [R18]
            mb <= m_rdata[23:16]; // [R7]
          end
          2'h1: src <= m_rdata;
          2'h2: dst <= m_rdata;
          default: begin
            cnt_a <= m_rdata[31:16];
            cnt_b <= m_rdata[15:0];
          end
        endcase
      end
    end else if (state == S_WR && m_ack) begin
      src <= src_nxt; // [R25]
      dst <= dst_nxt;
      unique case (ma.md)
        RDT_REPEAT: begin
          cnt_a[7:0] <= (cnt_a[7:0] == 8'h01) ? cnt_a[15:8] : cnt_a[7:0] - 8'h01; // [R2]
        end
        RDT_BLOCK: begin
          cnt_a[7:0] <= last_unit ? cnt_a[15:8] : cnt_a[7:0] - 8'h01; // [R3]
          if (last_unit) cnt_b <= cnt_b - 16'h0001; // [R4]
        end
        default: cnt_a <= cnt_a - 16'h0001; // [R1]
      endcase
    end
  end

  // pending requests and the cpu side; a new request beats the take clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend <= 16'h0000;
      cpu_irq <= 16'h0000;
      last_vec <= 4'h0;
      last_valid <= 1'b0;
      chained <= 1'b0;
    end else begin
      pend <= (pend & ~(take ? (16'h0001 << pick_v) : 16'h0000)) | (act_req & enable);
      cpu_irq <= (act_req & ~enable) |
                 ((state == S_END && (done_all || mb.irq_each)) ? vec_mask : 16'h0000); // [R22] [R11]
      if (take) chained <= 1'b0;
      if (state == S_BWR && m_ack && widx == wlast && mb.chain && done_all) chained <= 1'b1;
      if (state == S_END) begin
        last_vec <= vec;
        last_valid <= !chained; // [R14]
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/rdt_bus_model.sv
// behavioural internal bus: grant, word memory, prompt or slow answers
`timescale 1ns/100ps
`default_nettype none
module rdt_bus_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // engine side
  input wire logic bus_req,
  output logic bus_gnt,
  input wire rdt_pkg::rdt_mreq_t mreq,
  output logic [31:0] m_rdata,
  output logic m_ack,
  // extra wait cycles per access
  input wire logic [3:0] dly
);
  import rdt_pkg::*;
  logic [31:0] mem [logic [29:0]];
  logic [31:0] rdat;
  logic [3:0] wt;
  // idle data lines never repeat the last word, so a late sample shows up
  assign m_rdata = m_ack ? rdat : ~rdat;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_gnt <= 1'b0;
    end else begin
      bus_gnt <= bus_req;
    end
  end
  // one word per access; narrow writes land on the whole word
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      m_ack <= 1'b0;
      wt <= 4'h0;
      rdat <= 32'h0;
    end else if (mreq.req && !m_ack) begin
      if (wt >= dly) begin
        m_ack <= 1'b1;
        wt <= 4'h0;
        if (mreq.we) begin
          mem[mreq.addr[31:2]] = mreq.wdata;
        end else begin
          rdat <= mem[mreq.addr[31:2]];
        end
      end else begin
        wt <= wt + 4'h1;
      end
    end else begin
      m_ack <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== verification/rdt_top_checker.sv
// port level assertions for the transfer engine
`timescale 1ns/100ps
`default_nettype none
module rdt_top_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // internal bus
  input wire logic bus_req,
  input wire logic bus_gnt,
  input wire rdt_pkg::rdt_mreq_t mreq,
  input wire logic [31:0] m_rdata,
  input wire logic m_ack,
  // events
  input wire logic [15:0] act_req,
  input wire logic [15:0] cpu_irq,
  input wire logic busy
);
  import rdt_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register access not answered");
  wb_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("register ack longer than one cycle");
  hidden_regs_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h10 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  bus_owned_a: assert property (mreq.req |-> bus_req && busy)
    else $error("access without bus ownership");
  grant_first_a: assert property ($rose(bus_req) |-> !mreq.req)
    else $error("access before grant");
  req_hold_a: assert property (mreq.req && !m_ack |=> mreq.req && $stable(mreq.addr) && $stable(mreq.we))
    else $error("bus request changed before answer");
  req_drop_a: assert property (m_ack |=> !mreq.req)
    else $error("bus request held after answer");
  size_legal_a: assert property (mreq.req |-> mreq.size != RDT_SZ_RSV)
    else $error("reserved unit size on bus");
  irq_pulse_a: assert property (|cpu_irq |=> (cpu_irq & $past(cpu_irq)) == 16'h0)
    else $error("cpu interrupt wider than one cycle");
  release_end_a: assert property ($fell(bus_req) |-> !busy && !mreq.req)
    else $error("bus released while still active");
endmodule
bind rdt_top rdt_top_checker chk (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .bus_req, .bus_gnt, .mreq, .m_rdata, .m_ack,
  .act_req, .cpu_irq, .busy);
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench: register access, activations, chaining, modes, stop
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import rdt_pkg::*;
  logic sys_clk = 1'b0;
  logic rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, bus_req, bus_gnt, m_ack, busy;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, dly;
  logic [31:0] wb_dat_i, wb_dat_o, m_rdata, q;
  logic [15:0] act_req, cpu_irq;
  rdt_mreq_t mreq;
  int error_cnt = 0;
  int num_checks = 0;
  int irq_cnt [16];
  rdt_top dut (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .bus_req, .bus_gnt, .mreq, .m_rdata, .m_ack, .act_req, .cpu_irq, .busy);
  rdt_bus_model mdl (.sys_clk, .rst, .bus_req, .bus_gnt, .mreq, .m_rdata, .m_ack, .dly);
  always #5 sys_clk = ~sys_clk;
  // interrupt pulses are one cycle wide, so count them as they pass
  always @(posedge sys_clk) begin
    for (int k = 0; k < 16; k++) irq_cnt[k] += (cpu_irq[k] === 1'b1);
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge sys_clk);
      n++;
      if (n > 50) begin
        error_cnt++;
        wrap_up();
      end
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(q, e);
  endtask
  task wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl) begin
      @(posedge sys_clk);
      n++;
      if (n > 3000) begin
        error_cnt++;
        wrap_up();
      end
    end
  endtask
  task fire(input int i);
    @(posedge sys_clk);
    act_req[i] <= 1'b1;
    @(posedge sys_clk);
    act_req[i] <= 1'b0;
  endtask
  task run(input int i);
    fire(i);
    wait_busy(1'b1);
    wait_busy(1'b0);
    // closing irq pulse is counted on the edge that ends wait_busy, so look only after the next one
    @(posedge sys_clk);
  endtask
  task put(input logic [31:0] a, input logic [31:0] d);
    mdl.mem[a[31:2]] = d;
  endtask
  function automatic logic [31:0] mw(input logic [31:0] a);
    return mdl.mem[a[31:2]];
  endfunction
  initial begin
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hf;
    act_req = 16'h0;
    dly = 4'h0;
    // normal long: source up, destination down, two units
    put(32'h140c, 32'h2000);
    put(32'h2000, 32'h2830_0000);
    put(32'h2004, 32'h3000);
    put(32'h2008, 32'h4000);
    put(32'h200c, 32'h0002_0000);
    put(32'h3000, 32'hcafe_0001);
    put(32'h3004, 32'hcafe_0002);
    // block of three bytes chained to a fixed word descriptor
    put(32'h1414, 32'h2100);
    put(32'h2100, 32'h88a0_0000);
    put(32'h2104, 32'h3100);
    put(32'h2108, 32'h4100);
    put(32'h210c, 32'h0303_0001);
    put(32'h2110, 32'h1000_0000);
    put(32'h2114, 32'h3200);
    put(32'h2118, 32'h4200);
    put(32'h211c, 32'h0001_0000);
    put(32'h3100, 32'h1122_3344);
    put(32'h3200, 32'h5566_7788);
    // repeat long, reload of two
    put(32'h141c, 32'h2200);
    put(32'h2200, 32'h6820_0000);
    put(32'h2204, 32'h3300);
    put(32'h2208, 32'h4300);
    put(32'h220c, 32'h0201_0000);
    put(32'h3300, 32'h0bad_0001);
    put(32'h3304, 32'h0bad_0002);
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h0);
    rdc(8'h10, 32'h0);
    wb(1'b1, 8'h04, 32'hff);
    rdc(8'h04, 32'h7f);
    wb(1'b1, 8'h04, 32'h0);
    wb(1'b1, 8'h08, 32'h1000);
    rdc(8'h08, 32'h1000);
    wb(1'b1, 8'h00, 32'h00a8);
    rdc(8'h00, 32'h00a8);
    run(3);
    check(mw(32'h4000), 32'hcafe_0001);
    check(mw(32'h2004), 32'h3004);
    check(mw(32'h2008), 32'h3ffc);
    check(mw(32'h200c) >> 16, 32'h1);
    check(irq_cnt[3], 32'h0);
    run(3);
    check(mw(32'h3ffc), 32'hcafe_0002);
    check(mw(32'h200c) >> 16, 32'h0);
    check(irq_cnt[3], 32'h1);
    rdc(8'h00, 32'h00a0);
    // enable now clear: the event goes to the cpu instead
    fire(3);
    repeat (3) @(posedge sys_clk);
    check(busy, 1'b0);
    check(irq_cnt[3], 32'h2);
    dly <= 4'h3;
    run(5);
    check(mw(32'h2104), 32'h3103);
    check(mw(32'h2108), 32'h4103);
    check(mw(32'h210c) & 32'hffff, 32'h0);
    check(mw(32'h211c) >> 16, 32'h0);
    check(mw(32'h2114), 32'h3200);
    check(irq_cnt[5], 32'h1);
    dly <= 4'h0;
    run(7);
    check(mw(32'h220c) >> 16, 32'h0202);
    check(mw(32'h2204), 32'h3304);
    check(irq_cnt[7], 32'h0);
    rdc(8'h00, 32'h0080);
    // stopped engine keeps the event pending until released
    wb(1'b1, 8'h04, 32'h40);
    fire(7);
    repeat (8) @(posedge sys_clk);
    check(busy, 1'b0);
    wb(1'b1, 8'h04, 32'h0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    check(mw(32'h220c) >> 16, 32'h0201);
    // short format, word blocks, irq per activation, gap of one, read skip
    put(32'h1424, 32'h2300);
    put(32'h2300, 32'h9800_3400);
    put(32'h2304, 32'h6000_4400);
    put(32'h2308, 32'h0202_0002);
    put(32'h3400, 32'hfeed_beef);
    wb(1'b1, 8'h00, 32'h0200);
    wb(1'b1, 8'h04, 32'h27);
    run(9);
    check(mw(32'h2300), 32'h9800_3404);
    check(mw(32'h2308), 32'h0202_0001);
    check(mw(32'h4400), 32'hfeed_beef);
    check(irq_cnt[9], 32'h1);
    // stale count in ram: only a reused working copy finishes now
    put(32'h2308, 32'h0202_0005);
    run(9);
    check(mw(32'h2308), 32'h0202_0000);
    check(mw(32'h2304), 32'h6000_4408);
    check(irq_cnt[9], 32'h2);
    rdc(8'h00, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
